// ---- src/arp_regs.vh ----
`ifndef ARP_REGS_VH
`define ARP_REGS_VH
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define ARP_OFS_CFG      8'h00
`define ARP_OFS_TOUCH    8'h04
`define ARP_OFS_ZONE     8'h08
`define ARP_OFS_THR_AUX  8'h0C
`define ARP_OFS_THR_TA   8'h10
`define ARP_OFS_THR_TB   8'h14
`define ARP_OFS_STATUS   8'h18
`define ARP_OFS_RES0     8'h20
`define ARP_OFS_RES_LAST 8'h38
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define ARP_CFG_MED      1:0
`define ARP_CFG_AVG      3:2
`define ARP_CFG_RES12    4
`define ARP_CFG_CLKDIV   6:5
`define ARP_CFG_PENIRQ   7
`define ARP_TCH_PRE      7:0
`define ARP_TCH_SNS      15:8
`define ARP_THR_LO       11:0
`define ARP_THR_HI       27:16
`define ARP_ST_DAV       2:0
`define ARP_ST_PEN       3
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define ARP_RST_CFG      8'h20
`define ARP_RST_TOUCH    16'h0404
`define ARP_RST_ZONE     9'h000
`define ARP_RST_THR      24'hFFF000
// ------------------------------------------------------------
// channel numbers and zone codes
// ------------------------------------------------------------
`define ARP_CH_AUX       3'h4
`define ARP_ZN_HIGH      2'h0
`define ARP_ZN_MID       2'h1
`define ARP_ZN_LOW       2'h2
`endif

// ---- src/arp_top.v ----
`timescale 1ns/1ps
`default_nettype none
`include "arp_regs.vh"
module arp_top (
    input  wire        clk,
    input  wire        rst,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        smp_valid,
    input  wire [2:0]  smp_chan,
    input  wire [11:0] smp_data,
    input  wire        meas_active,
    input  wire        recheck_req,
    input  wire        xp_level,
    output reg         conv_clk_tick,
    output reg         res12_eff,
    output reg         xp_pullup_en,
    output reg         xp_precharge_en,
    output reg         pen_touch_n,
    output reg         recheck_done,
    output reg         data_avail_irq_pin_n
);
// ------------------------------------------------------------
// configuration registers
// ------------------------------------------------------------
reg  [7:0]  cfg_ff;
reg  [15:0] touch_ff;
reg  [8:0]  zone_ff;
reg  [23:0] thr_ff [0:2];
reg  [2:0]  dav_ff;
reg  [11:0] res_ff [0:6];
wire [31:0] wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                     {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
wire        wr_go = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
wire [7:0]  wa    = s_axi_awaddr;
wire [31:0] wd    = s_axi_wdata & wmask;
wire [2:0]  dav_clr = (wr_go && wa == `ARP_OFS_STATUS) ? wd[`ARP_ST_DAV] : 3'h0;
reg  [2:0]  dav_set;
wire [1:0]  clkdiv = cfg_ff[`ARP_CFG_CLKDIV];
// ------------------------------------------------------------
// register bus write side
// ------------------------------------------------------------
always @(posedge clk) begin
    if (rst) begin
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b0;
        s_axi_bresp   <= 2'h0;
        cfg_ff        <= `ARP_RST_CFG;
        touch_ff      <= `ARP_RST_TOUCH;
        zone_ff       <= `ARP_RST_ZONE;
        thr_ff[0]     <= `ARP_RST_THR;
        thr_ff[1]     <= `ARP_RST_THR;
        thr_ff[2]     <= `ARP_RST_THR;
    end else begin
        s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
        s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
        if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
        if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= 2'h0;
            case (wa)
            `ARP_OFS_CFG:     cfg_ff   <= (cfg_ff & ~wmask[7:0]) | wd[7:0];
            `ARP_OFS_TOUCH:   touch_ff <= (touch_ff & ~wmask[15:0]) | wd[15:0];
            `ARP_OFS_ZONE:    zone_ff  <= (zone_ff & ~wmask[8:0]) | wd[8:0];
            `ARP_OFS_THR_AUX: thr_ff[0] <= {wd[`ARP_THR_HI], wd[`ARP_THR_LO]};
            `ARP_OFS_THR_TA:  thr_ff[1] <= {wd[`ARP_THR_HI], wd[`ARP_THR_LO]};
            `ARP_OFS_THR_TB:  thr_ff[2] <= {wd[`ARP_THR_HI], wd[`ARP_THR_LO]};
            `ARP_OFS_STATUS: begin
            end
            default:          s_axi_bresp <= 2'h2;
            endcase
        end
    end
end
// ------------------------------------------------------------
// register bus read side
// ------------------------------------------------------------
reg [31:0] rd_val;
reg        rd_ok;
always @* begin
    rd_val = 32'h0;
    rd_ok  = 1'b1;
    case (s_axi_araddr)
    `ARP_OFS_CFG:     rd_val = {24'h0, cfg_ff};
    `ARP_OFS_TOUCH:   rd_val = {16'h0, touch_ff};
    `ARP_OFS_ZONE:    rd_val = {23'h0, zone_ff};
    `ARP_OFS_THR_AUX: rd_val = {4'h0, thr_ff[0][23:12], 4'h0, thr_ff[0][11:0]};
    `ARP_OFS_THR_TA:  rd_val = {4'h0, thr_ff[1][23:12], 4'h0, thr_ff[1][11:0]};
    `ARP_OFS_THR_TB:  rd_val = {4'h0, thr_ff[2][23:12], 4'h0, thr_ff[2][11:0]};
    `ARP_OFS_STATUS:  rd_val = {28'h0, pen_touch_n, dav_ff};
    default: begin
        if (s_axi_araddr >= `ARP_OFS_RES0 && s_axi_araddr <= `ARP_OFS_RES_LAST &&
            s_axi_araddr[1:0] == 2'h0)
            rd_val = {20'h0, res_ff[s_axi_araddr[4:2]]};
        else
            rd_ok = 1'b0;
    end
    endcase
end

always @(posedge clk) begin
    if (rst) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b0;
        s_axi_rdata   <= 32'h0;
        s_axi_rresp   <= 2'h0;
    end else begin
        s_axi_arready <= s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
        if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
        if (s_axi_arready && s_axi_arvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
        end
    end
end
// ------------------------------------------------------------
// conversion clock and resolution
// ------------------------------------------------------------
reg [2:0] div_cnt_ff;
wire [2:0] div_last = (3'h1 << clkdiv) - 3'h1;
always @(posedge clk) begin
    if (rst) begin
        div_cnt_ff    <= 3'h0;
        conv_clk_tick <= 1'b0;
        res12_eff     <= 1'b0;
    end else begin
        div_cnt_ff    <= (div_cnt_ff >= div_last) ? 3'h0 : div_cnt_ff + 3'h1;
        conv_clk_tick <= (div_cnt_ff >= div_last);
        res12_eff     <= cfg_ff[`ARP_CFG_RES12] && (clkdiv != 2'h0);
    end
end
// ------------------------------------------------------------
// touch detect: precharge then sense
// ------------------------------------------------------------
localparam [3:0] TS_IDLE = 4'h1;
localparam [3:0] TS_MEAS = 4'h2;
localparam [3:0] TS_PRE  = 4'h4;
localparam [3:0] TS_SNS  = 4'h8;
reg [3:0] ts_ff;
reg [7:0] ts_cnt_ff;
reg       xp_s1_ff;
reg       xp_s2_ff;
always @(posedge clk) begin
    if (rst) begin
        xp_s1_ff        <= 1'b1;
        xp_s2_ff        <= 1'b1;
        ts_ff           <= TS_IDLE;
        ts_cnt_ff       <= 8'h0;
        xp_pullup_en    <= 1'b1;
        xp_precharge_en <= 1'b0;
        pen_touch_n     <= 1'b1;
        recheck_done    <= 1'b0;
    end else begin
        xp_s1_ff     <= xp_level;
        xp_s2_ff     <= xp_s1_ff;
        recheck_done <= 1'b0;
        case (ts_ff)
        TS_IDLE: begin
            pen_touch_n <= xp_s2_ff;
            if (meas_active) begin
                ts_ff        <= TS_MEAS;
                xp_pullup_en <= 1'b0;
            end else if (recheck_req) begin
                ts_ff           <= TS_PRE;
                ts_cnt_ff       <= touch_ff[`ARP_TCH_PRE];
                xp_pullup_en    <= 1'b1;
                xp_precharge_en <= 1'b1;
            end
        end
        TS_MEAS: begin
            if (!meas_active) begin
                ts_ff           <= TS_PRE;
                ts_cnt_ff       <= touch_ff[`ARP_TCH_PRE];
                xp_pullup_en    <= 1'b1;
                xp_precharge_en <= 1'b1;
            end
        end
        TS_PRE: begin
            ts_cnt_ff <= ts_cnt_ff - 8'h1;
            // measurement starting mid-recheck wins; the pull-up must drop
            if (meas_active) begin
                ts_ff           <= TS_MEAS;
                xp_pullup_en    <= 1'b0;
                xp_precharge_en <= 1'b0;
            end else if (ts_cnt_ff <= 8'h1) begin
                ts_ff           <= TS_SNS;
                ts_cnt_ff       <= touch_ff[`ARP_TCH_SNS];
                xp_precharge_en <= 1'b0;
            end
        end
        TS_SNS: begin
            ts_cnt_ff <= ts_cnt_ff - 8'h1;
            // an abandoned sense leaves the last pen state standing
            if (meas_active) begin
                ts_ff        <= TS_MEAS;
                xp_pullup_en <= 1'b0;
            end else if (ts_cnt_ff <= 8'h1) begin
                ts_ff        <= TS_IDLE;
                pen_touch_n  <= xp_s2_ff;
                recheck_done <= 1'b1;
            end
        end
        default: ts_ff <= TS_IDLE;
        endcase
    end
end
// ------------------------------------------------------------
// filter size decode
// ------------------------------------------------------------
reg [4:0] n_need;
reg [3:0] lo_i;
reg [3:0] hi_i;
reg [3:0] med_i;
reg       dbl;
reg [2:0] sh;
always @* begin
    n_need = 5'd1;
    lo_i   = 4'd0;
    hi_i   = 4'd0;
    med_i  = 4'd0;
    dbl    = 1'b0;
    sh     = 3'd0;
    case (cfg_ff[`ARP_CFG_MED])
    2'h1: begin n_need = 5'd3;  med_i = 4'd1; end
    2'h2: begin n_need = 5'd7;  med_i = 4'd3; end
    2'h3: begin n_need = 5'd15; med_i = 4'd7; end
    default: begin end
    endcase
    lo_i = med_i;
    hi_i = med_i;
    if (cfg_ff[`ARP_CFG_MED] == 2'h0) begin
        case (cfg_ff[`ARP_CFG_AVG])
        2'h1: begin n_need = 5'd4;  hi_i = 4'd3;  sh = 3'd2; end
        2'h2: begin n_need = 5'd8;  hi_i = 4'd7;  sh = 3'd3; end
        2'h3: begin n_need = 5'd16; hi_i = 4'd15; sh = 3'd4; end
        default: begin end
        endcase
    end else if (cfg_ff[`ARP_CFG_AVG] == 2'h1 && cfg_ff[`ARP_CFG_MED] != 2'h1) begin
        lo_i = med_i - 4'd1;
        hi_i = med_i + 4'd1;
        dbl  = 1'b1;
        sh   = 3'd2;
    end else if (cfg_ff[`ARP_CFG_AVG] == 2'h2 && cfg_ff[`ARP_CFG_MED] == 2'h3) begin
        lo_i = 4'd4;
        hi_i = 4'd10;
        dbl  = 1'b1;
        sh   = 3'd3;
    end
end
// ------------------------------------------------------------
// sample acceptance
// ------------------------------------------------------------
// channel 7 carries no result and must not disturb a batch
wire        smp_take = smp_valid && (smp_chan <= 3'h6);
reg  [4:0]  flt_cfg_ff;
// ------------------------------------------------------------
// sorted sample store, insertion per entry
// ------------------------------------------------------------
reg  [11:0] srt_ff [0:15];
reg  [4:0]  cnt_ff;
reg  [2:0]  chan_ff;
wire [11:0] smp_v = res12_eff ? smp_data : {2'h0, smp_data[11:2]};
// a new channel or a changed filter setting starts a fresh batch
wire        restart = (chan_ff != smp_chan) || (cnt_ff >= n_need) ||
                      (flt_cfg_ff != cfg_ff[4:0]);
wire [4:0]  cnt_use = restart ? 5'd0 : cnt_ff;
wire [15:0] keep;
genvar gi;
generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_srt
        assign keep[gi] = (gi < cnt_use) && !(srt_ff[gi] > smp_v);
        always @(posedge clk) begin
            if (rst)
                srt_ff[gi] <= 12'h0;
            else if (smp_take && !keep[gi])
                srt_ff[gi] <= (gi == 0) ? smp_v : (keep[(gi + 15) % 16] ? smp_v
                                                   : srt_ff[(gi + 15) % 16]);
        end
    end
endgenerate
// ------------------------------------------------------------
// window sum and output
// ------------------------------------------------------------
reg  [16:0] win_sum;
integer     k;
always @* begin
    win_sum = dbl ? {5'h0, srt_ff[med_i]} : 17'h0;
    for (k = 0; k < 16; k = k + 1) begin
        if (k >= lo_i && k <= hi_i)
            win_sum = win_sum + {5'h0, srt_ff[k]};
    end
end
wire [16:0] flt_full = win_sum >> sh;
wire [11:0] flt_val  = flt_full[11:0];
reg         flt_rdy_ff;
reg  [2:0]  flt_ch_ff;
always @(posedge clk) begin
    if (rst) begin
        cnt_ff     <= 5'd0;
        chan_ff    <= 3'h0;
        flt_rdy_ff <= 1'b0;
        flt_ch_ff  <= 3'h0;
        flt_cfg_ff <= 5'h0;
    end else begin
        flt_rdy_ff <= 1'b0;
        if (smp_take) begin
            chan_ff    <= smp_chan;
            flt_cfg_ff <= cfg_ff[4:0];
            cnt_ff     <= cnt_use + 5'd1;
            flt_rdy_ff <= (cnt_use + 5'd1 == n_need);
            flt_ch_ff  <= smp_chan;
        end
    end
end
// ------------------------------------------------------------
// zone detection and result storage
// ------------------------------------------------------------
wire        zch  = (flt_ch_ff >= `ARP_CH_AUX);
// touch channels look at slot 0 only; their results never reach the flags
wire [1:0]  zi   = zch ? flt_ch_ff[1:0] : 2'h0;
wire [11:0] z_hi = thr_ff[zi][23:12];
wire [11:0] z_lo = thr_ff[zi][11:0];
wire [2:0]  zctl = zone_ff[zi * 3 +: 3];
reg         z_hit;
always @* begin
    case (zctl[2:1])
    `ARP_ZN_HIGH: z_hit = (flt_val >= z_hi);
    `ARP_ZN_MID:  z_hit = (flt_val > z_lo) && (flt_val < z_hi);
    `ARP_ZN_LOW:  z_hit = (flt_val <= z_lo);
    default:      z_hit = 1'b0;
    endcase
    dav_set = 3'h0;
    if (flt_rdy_ff && zch && zctl[0] && z_hit)
        dav_set[zi] = 1'b1;
end
wire store = flt_rdy_ff && !(zch && zctl[0] && !z_hit);
integer r;
always @(posedge clk) begin
    if (rst) begin
        for (r = 0; r < 7; r = r + 1)
            res_ff[r] <= 12'h0;
        dav_ff               <= 3'h0;
        data_avail_irq_pin_n <= 1'b1;
    end else begin
        if (store)
            res_ff[flt_ch_ff] <= flt_val;
        dav_ff <= (dav_ff & ~dav_clr) | dav_set;
        data_avail_irq_pin_n <= !((|dav_ff) || (|dav_set) ||
                                  (cfg_ff[`ARP_CFG_PENIRQ] && !pen_touch_n));
    end
end
endmodule
`default_nettype wire

// ---- verif/arp_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module arp_chk (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        meas_active,
    input wire logic        recheck_req,
    input wire logic        conv_clk_tick,
    input wire logic        res12_eff,
    input wire logic        xp_pullup_en,
    input wire logic        xp_precharge_en,
    input wire logic        recheck_done
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // register bus
    // ----------------------------------------
    property p_wr_resp; s_axi_awready |=> s_axi_bvalid; endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("no write response");
    property p_wr_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write response dropped");
    property p_rd_resp; s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd_resp: assert property (p_rd_resp) else $error("no read data");
    property p_rd_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
    // ----------------------------------------
    // panel and converter
    // ----------------------------------------
    property p_no_pullup; meas_active && $past(meas_active) |-> !xp_pullup_en; endproperty
    a_no_pullup: assert property (p_no_pullup) else $error("pull-up on in measurement");
    property p_pre_pullup; xp_precharge_en |-> xp_pullup_en; endproperty
    a_pre_pullup: assert property (p_pre_pullup) else $error("pull-up off in recheck");
    property p_pre_start;
        recheck_req && !xp_precharge_en && !meas_active |-> ##[1:3] xp_precharge_en;
    endproperty
    a_pre_start: assert property (p_pre_start) else $error("no precharge");
    property p_done_pulse; recheck_done |-> !xp_precharge_en ##1 !recheck_done; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("bad sense end");
    property p_res12; res12_eff && conv_clk_tick |=> !conv_clk_tick; endproperty
    a_res12: assert property (p_res12) else $error("twelve bits on undivided clock");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_recheck: cover property (recheck_done);
    c_res12: cover property (res12_eff && conv_clk_tick);
endmodule
bind arp_top arp_chk u_chk (
    .clk(clk), .rst(rst), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .meas_active(meas_active), .recheck_req(recheck_req), .conv_clk_tick(conv_clk_tick),
    .res12_eff(res12_eff), .xp_pullup_en(xp_pullup_en), .xp_precharge_en(xp_precharge_en),
    .recheck_done(recheck_done)
);
`default_nettype wire

// ---- verif/arp_panel.sv ----
`timescale 1ns/1ps
`default_nettype none
module arp_panel (
    input  wire logic clk,
    input  wire logic touched,
    input  wire logic xp_pullup_en,
    input  wire logic xp_precharge_en,
    output var  logic xp_level
);
    logic flt_ff = 1'h0;
    always @(posedge clk) flt_ff <= ~flt_ff;
    // touch grounds the positive X terminal; undriven node has no defined level
    always_comb begin
        if (touched) xp_level = 1'h0;
        else if (xp_pullup_en || xp_precharge_en) xp_level = 1'h1;
        else xp_level = flt_ff;
    end
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk = 1'h0, rst = 1'h1;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rd, prev;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0;
    logic        rready = 1'h0, smp_valid = 1'h0, meas_active = 1'h0;
    logic        recheck_req = 1'h0, touched = 1'h0;
    logic [2:0]  smp_chan = 3'h0;
    logic [11:0] smp_data = 12'h0;
    logic [11:0] v[$];
    logic [11:0] pv[3] = '{12'h800, 12'h7FF, 12'h100};
    logic [11:0] fv[3] = '{12'h7FF, 12'h800, 12'h101};
    logic [1:0]  rsp;
    wire         awready, wready, bvalid, arready, rvalid, xp_level;
    wire         tick, r12, pull, pre, pen_n, done, irq_n;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    logic [31:0] mcfg[3] = '{32'h37, 32'h3B, 32'h35}, mexp[3] = '{32'h40, 32'h43, 32'h4};
    int          mn[3] = '{15, 15, 3};
    int          err_total = 0, tests_run = 0, cnt;

    always #2 clk = ~clk;

    arp_top DUT (
        .clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .smp_valid(smp_valid), .smp_chan(smp_chan), .smp_data(smp_data),
        .meas_active(meas_active), .recheck_req(recheck_req), .xp_level(xp_level),
        .conv_clk_tick(tick), .res12_eff(r12), .xp_pullup_en(pull),
        .xp_precharge_en(pre), .pen_touch_n(pen_n), .recheck_done(done),
        .data_avail_irq_pin_n(irq_n)
    );
    arp_panel u_panel (
        .clk(clk), .touched(touched), .xp_pullup_en(pull), .xp_precharge_en(pre),
        .xp_level(xp_level)
    );

    // ----------------------------------------
    // bus and sample tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid && n < 50);
        bready <= 1'h0;
        rsp = bresp;
        chk(32'(n < 50), 32'h1, "write answer");
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string m);
        int n;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'h1;
        rready  <= 1'h1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'h0;
        end while (!rvalid && n < 50);
        rready <= 1'h0;
        rsp = rresp;
        chk(32'(n < 50), 32'h1, "read answer");
        chk(rdata, exp, m);
    endtask
    task automatic burst(input logic [2:0] ch, input int n);
        @(posedge clk);
        for (int i = 0; i < n; i++) begin
            smp_valid <= 1'h1;
            smp_chan  <= ch;
            smp_data  <= v[i];
            @(posedge clk);
        end
        smp_valid <= 1'h0;
        repeat (3) @(posedge clk);
    endtask
    task automatic wdone;
        int n;
        n = 0;
        while (!done && n < 200) begin
            @(posedge clk);
            n++;
        end
        chk(32'(n < 200), 32'h1, "recheck end");
        repeat (2) @(posedge clk);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        #100000;
        err_total++;
        final_report();
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        rc(8'h00, 32'h20, "cfg reset");
        rc(8'h04, 32'h404, "touch reset");
        rc(8'h0C, 32'h0FFF0000, "thr reset");
        rc(8'h1C, 32'h0, "unmapped");
        chk(rsp, 2'h2, "unmapped resp");
        wr(8'h1C, 32'h1);
        chk(rsp, 2'h2, "unmapped write");
        chk(irq_n, 1'h1, "irq idle");
        $display("test reset done");
        for (int k = 0; k < 4; k++) begin
            wr(8'h00, 32'h10 | k << 5);
            repeat (4) @(posedge clk);
            cnt = 0;
            repeat (16) begin
                @(posedge clk);
                cnt += tick;
            end
            chk(cnt, 16 >> k, "tick count");
            chk(r12, 32'(k != 0), "res12");
        end
        $display("test clock done");
        wr(8'h00, 32'h20);
        v = '{12'hABC};
        burst(3'h4, 1);
        rc(8'h30, 32'h2AF, "ten bit");
        wr(8'h00, 32'h30);
        burst(3'h4, 1);
        rc(8'h30, 32'hABC, "bypass");
        for (int c = 1; c < 4; c++) begin
            wr(8'h00, 32'h30 | c << 2);
            v = {};
            for (int i = 1; i <= (2 << c); i++) v.push_back(12'(i));
            burst(3'h0, 2 << c);
            rc(8'h20, ((2 << c) + 1) >> 1, "average");
        end
        for (int m = 1; m < 4; m++) begin
            wr(8'h00, 32'h30 | m);
            v = {};
            for (int i = 0; i < (2 << m) - 1; i++) v.push_back(12'(i * 2 % ((2 << m) - 1) + 1));
            burst(3'(m), (2 << m) - 1);
            rc(8'h20 + 8'(m * 4), 1 << m, "median");
        end
        v = '{12'hFA, 12'h1, 12'hC8, 12'h3, 12'h64, 12'h2, 12'h4};
        wr(8'h00, 32'h36);
        burst(3'h5, 7);
        rc(8'h34, 32'h1B, "median avg");
        wr(8'h00, 32'h3A);
        burst(3'h6, 7);
        rc(8'h38, 32'h4, "invalid combo");
        v = {};
        for (int i = 1; i <= 15; i++) v.push_back(12'(i * i));
        for (int j = 0; j < 3; j++) begin
            wr(8'h00, mcfg[j]);
            burst(3'h5, mn[j]);
            rc(8'h34, mexp[j], "median window");
        end
        $display("test filter done");
        wr(8'h00, 32'h30);
        wr(8'h0C, 32'h08000100);
        wr(8'h18, 32'h7);
        chk(rsp, 2'h0, "write okay");
        prev = 32'hABC;
        for (int z = 0; z < 3; z++) begin
            wr(8'h08, 32'(z * 2 + 1));
            v = '{fv[z]};
            burst(3'h4, 1);
            rc(8'h30, prev, "zone discard");
            chk(irq_n, 1'h1, "irq quiet");
            v = '{pv[z]};
            burst(3'h4, 1);
            rc(8'h30, 32'(pv[z]), "zone keep");
            rc(8'h18, 32'h9, "flag set");
            chk(irq_n, 1'h0, "irq low");
            wr(8'h18, 32'h1);
            repeat (2) @(posedge clk);
            chk(irq_n, 1'h1, "irq clear");
            prev = 32'(pv[z]);
        end
        wr(8'h08, 32'h7);
        v = '{12'h555};
        burst(3'h4, 1);
        rc(8'h30, prev, "zone never");
        chk(irq_n, 1'h1, "irq never");
        $display("test zone done");
        wr(8'h00, 32'hB0);
        touched <= 1'h1;
        @(posedge clk) recheck_req <= 1'h1;
        @(posedge clk) recheck_req <= 1'h0;
        wdone();
        chk(pen_n, 1'h0, "pen touched");
        chk(irq_n, 1'h0, "pen irq");
        meas_active <= 1'h1;
        repeat (3) @(posedge clk);
        chk(pull, 1'h0, "pullup off");
        touched <= 1'h0;
        meas_active <= 1'h0;
        wdone();
        chk(pen_n, 1'h1, "released");
        chk(irq_n, 1'h1, "pen irq off");
        $display("test touch done");
        final_report();
    end
endmodule
`default_nettype wire
